// ==== verilog/asa_ctrl.sv ====
// Controller that drives an asynchronous static memory through its pins.
`timescale 1ns/100ps
`default_nettype none

module asa_ctrl
  import asa_pkg::*;
#(
  parameter int ADDR_W = 19,
  parameter int DATA_W = 8
) (
  input  wire logic              clk,
  input  wire logic              resetn,
  input  wire logic              req_valid,
  output var  logic              req_ready,
  input  wire logic              req_write,
  input  wire logic [ADDR_W-1:0] req_addr,
  input  wire logic [DATA_W-1:0] req_wdata,
  output var  logic              rsp_valid,
  output var  logic [DATA_W-1:0] rsp_rdata,
  output var  logic              done,
  input  wire logic              retention_req,
  output var  logic              retention_ready,
  output var  logic [ADDR_W-1:0] word_address,
  output var  logic              sram_select_n,
  output var  logic              sram_write_n,
  output var  logic              sram_gate_n,
  output var  logic [DATA_W-1:0] byte_lines_o,
  output var  logic              byte_lines_oe,
  input  wire logic [DATA_W-1:0] byte_lines_i
);

  import asa_pkg::*;

  asa_state_type     state_reg;
  asa_state_type     state_next;
  logic [CNT_W-1:0]  cnt_reg;
  logic              write_reg;
  logic              phase_end;
  logic              take;
  logic [DATA_W-1:0] rd_sync;

  // ****************************************
  // Read data synchroniser
  // ****************************************

  // Pins are asynchronous, so the capture point allows for the two stages.
  asa_sync #(
    .WIDTH    (DATA_W)
  ) u_sync (
    .clk      (clk),
    .resetn   (resetn),
    .async_in (byte_lines_i),
    .sync_out (rd_sync)
  );

  // ****************************************
  // Phase sequencing
  // ****************************************

  // A request is taken only while ready is shown, so retention blocks new work.
  assign take = req_valid && req_ready;

  // Each phase ends when its counter reaches the last cycle of its length.
  always_comb begin
    phase_end = 1'b0;
    case (state_reg)
      ST_SETUP:   phase_end = (cnt_reg == SETUP_LAST);
      ST_STROBE:  phase_end = write_reg ? (cnt_reg == WRITE_STROBE_LAST) :
                                          (cnt_reg == READ_STROBE_LAST);
      ST_RECOVER: phase_end = (cnt_reg == RECOVER_LAST);
      default:    phase_end = 1'b0;
    endcase
  end

  // Address setup, strobe and recovery in fixed order, then back to idle.
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE:    if (take) state_next = ST_SETUP;
      ST_SETUP:   if (phase_end) state_next = ST_STROBE;
      ST_STROBE:  if (phase_end) state_next = ST_RECOVER;
      ST_RECOVER: if (phase_end) state_next = ST_IDLE;
      default:    state_next = ST_IDLE;
    endcase
  end

  // State and phase counter.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_reg <= ST_IDLE;
      cnt_reg   <= CNT_ZERO;
    end else begin
      state_reg <= state_next;
      if (state_next != state_reg) begin
        cnt_reg <= CNT_ZERO;
      end else begin
        cnt_reg <= cnt_reg + 4'h1;
      end
    end
  end

  // Request is latched on acceptance; address holds until the next request.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      write_reg    <= 1'b0;
      word_address <= '0;
      byte_lines_o <= '0;
    end else if (take) begin
      write_reg    <= req_write;
      word_address <= req_addr;
      byte_lines_o <= req_wdata;
    end
  end

  // ****************************************
  // Memory strobes
  // ****************************************

  // Select and write strobe fall and rise on the same edge, so the write
  // window is the whole strobe phase and both edges end it together.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sram_select_n <= 1'b1;
      sram_write_n  <= 1'b1;
      sram_gate_n   <= 1'b1;
    end else begin
      sram_select_n <= (state_next != ST_STROBE);
      sram_write_n  <= !((state_next == ST_STROBE) && write_reg);
      sram_gate_n   <= !((state_next == ST_STROBE) && !write_reg);
    end
  end

  // Data is driven from setup to the end of the first recovery cycle, giving
  // setup before and hold after the ending edge. The memory has released the
  // lines by then because the gate stayed high all through the write.
  // The drive decision uses the request being taken, never the latched kind
  // of the previous access, so a read after a write cannot turn the drive on.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      byte_lines_oe <= 1'b0;
    end else if (take) begin
      byte_lines_oe <= req_write;
    end else if (state_reg == ST_RECOVER) begin
      byte_lines_oe <= 1'b0;
    end
  end

  // ****************************************
  // User side answers
  // ****************************************

  // Read data is captured on the last strobe edge, after access time and sync.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rsp_valid <= 1'b0;
      rsp_rdata <= '0;
    end else begin
      rsp_valid <= 1'b0;
      if ((state_reg == ST_STROBE) && phase_end && !write_reg) begin
        rsp_valid <= 1'b1;
        rsp_rdata <= rd_sync;
      end
    end
  end

  // Ready and done; recovery covers the memory turn-off before the next drive.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      req_ready       <= 1'b0;
      done            <= 1'b0;
      retention_ready <= 1'b0;
    end else begin
      req_ready       <= (state_next == ST_IDLE) && !retention_req;
      done            <= (state_reg == ST_RECOVER) && phase_end;
      retention_ready <= (state_next == ST_IDLE) && retention_req;
    end
  end

  // ****************************************
  // Checks
  // ****************************************

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  a_read_strobe_high: assert property (!sram_gate_n |-> sram_write_n)
    else $error("write strobe low during read");
  a_read_cycle_len: assert property ($fell(sram_gate_n) |-> !sram_gate_n [*8])
    else $error("read strobe shorter than access plus sync");
  a_write_pulse_len: assert property ($fell(sram_write_n) |-> !sram_write_n [*5])
    else $error("write pulse too short");
  a_write_needs_sel: assert property (!sram_write_n |-> !sram_select_n)
    else $error("write strobe without select");
  a_write_end_both: assert property ($rose(sram_write_n) |-> $rose(sram_select_n))
    else $error("select and strobe did not end together");
  a_select_before_end: assert property ($rose(sram_write_n) |-> $past(sram_select_n, 5) == 1'b0)
    else $error("select low too briefly before write end");
  a_data_setup_hold: assert property ($rose(sram_write_n) |->
                                      byte_lines_oe && $past(byte_lines_oe, 4))
    else $error("write data setup or hold broken");
  a_addr_stable: assert property ($fell(sram_write_n) |-> $stable(word_address) [*5])
    else $error("address moved during write");
  a_no_contention: assert property ($rose(sram_gate_n) |-> !byte_lines_oe [*2])
    else $error("data driven before memory released");
  a_drive_gate_high: assert property (byte_lines_oe |-> sram_gate_n)
    else $error("data driven while gate low");
  a_retention_desel: assert property (retention_ready |-> sram_select_n)
    else $error("retention with select low");
  a_read_answer: assert property ($fell(sram_gate_n) |-> ##8 rsp_valid)
    else $error("read answer not at strobe end");

  c_read: cover property ($fell(sram_gate_n) ##[1:20] rsp_valid);
  c_write: cover property ($rose(sram_write_n) ##[1:10] done);
  c_retention: cover property (retention_ready);
  c_write_then_read: cover property ($rose(sram_write_n) ##[1:20] $fell(sram_gate_n));

endmodule
`default_nettype wire

// ==== verilog/asa_pkg.sv ====
// Constants shared by the asynchronous static memory access controller.
`default_nettype none
package asa_pkg;

  // ****************************************
  // Clock and memory timing figures
  // ****************************************
  localparam int CLK_PERIOD_NS              = 10;
  localparam int READ_CYCLE_MIN_NS          = 55;  // read_cycle_min
  localparam int ADDRESS_ACCESS_MAX_NS      = 55;  // address_access_max
  localparam int SELECT_ACCESS_MAX_NS       = 55;  // select_access_max
  localparam int GATE_ACCESS_MAX_NS         = 25;  // gate_access_max
  localparam int OUTPUT_HOLD_AFTER_ADDR_NS  = 10;  // output_hold_after_addr
  localparam int WRITE_CYCLE_MIN_NS         = 55;  // write_cycle_min
  localparam int WRITE_PULSE_MIN_NS         = 40;  // write_pulse_min
  localparam int WRITE_DATA_SETUP_NS        = 25;  // write_data_setup
  localparam int RELEASE_AFTER_WRITE_NS     = 20;  // release_after_write_strobe
  localparam int RELEASE_AFTER_GATE_NS      = 20;
  localparam int SELECT_TO_WRITE_END_NS     = 40;
  localparam int DESELECT_TO_RETENTION_NS   = 0;   // deselect_to_retention

  // ****************************************
  // Derived cycle counts, minimums rounded up
  // ****************************************
  localparam int SYNC_STAGES        = 2;
  localparam int ACCESS_NS          = (ADDRESS_ACCESS_MAX_NS > SELECT_ACCESS_MAX_NS) ?
                                      ADDRESS_ACCESS_MAX_NS : SELECT_ACCESS_MAX_NS;
  localparam int ACCESS_CYC         = (ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int READ_STROBE_CYC    = ACCESS_CYC + SYNC_STAGES;
  localparam int WPULSE_NS          = (WRITE_PULSE_MIN_NS >
                                       WRITE_DATA_SETUP_NS + RELEASE_AFTER_WRITE_NS) ?
                                      WRITE_PULSE_MIN_NS :
                                      WRITE_DATA_SETUP_NS + RELEASE_AFTER_WRITE_NS;
  localparam int WRITE_STROBE_CYC   = (WPULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SETUP_CYC          = 1;
  localparam int TURN_CYC           = (RELEASE_AFTER_GATE_NS + CLK_PERIOD_NS - 1) /
                                      CLK_PERIOD_NS;
  localparam int WCYC               = (WRITE_CYCLE_MIN_NS + CLK_PERIOD_NS - 1) /
                                      CLK_PERIOD_NS;
  localparam int WREST_CYC          = WCYC - SETUP_CYC - WRITE_STROBE_CYC;
  localparam int RECOVER_CYC        = (TURN_CYC > WREST_CYC) ? TURN_CYC :
                                      ((WREST_CYC < 1) ? 1 : WREST_CYC);

  // ****************************************
  // Phase counter
  // ****************************************
  localparam int               CNT_W            = 4;
  localparam logic [CNT_W-1:0] CNT_ZERO         = 4'h0;
  localparam logic [CNT_W-1:0] SETUP_LAST       = CNT_W'(SETUP_CYC - 1);
  localparam logic [CNT_W-1:0] READ_STROBE_LAST = CNT_W'(READ_STROBE_CYC - 1);
  localparam logic [CNT_W-1:0] WRITE_STROBE_LAST = CNT_W'(WRITE_STROBE_CYC - 1);
  localparam logic [CNT_W-1:0] RECOVER_LAST     = CNT_W'(RECOVER_CYC - 1);

  // ****************************************
  // Access phases
  // ****************************************
  typedef enum logic [1:0] {
    ST_IDLE    = 2'b00,
    ST_SETUP   = 2'b01,
    ST_STROBE  = 2'b10,
    ST_RECOVER = 2'b11
  } asa_state_type;

endpackage
`default_nettype wire

// ==== verilog/asa_sync.sv ====
// Two flip-flop synchroniser for the data lines read back from the memory.
`timescale 1ns/100ps
`default_nettype none

module asa_sync #(
  parameter int WIDTH = 8
) (
  input  wire logic             clk,
  input  wire logic             resetn,
  input  wire logic [WIDTH-1:0] async_in,
  output var  logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_reg;

  // The first stage feeds only the second stage, never any logic.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      meta_reg <= '0;
      sync_out <= '0;
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end

endmodule
`default_nettype wire

// ==== verification/asa_mem_model.sv ====
// Behavioural model of the asynchronous static memory on the far side of the controller.
`timescale 1ns/100ps
`default_nettype none

module asa_mem_model (
  input  wire logic        slow,
  input  wire logic [18:0] word_address,
  input  wire logic        sram_select_n,
  input  wire logic        sram_write_n,
  input  wire logic        sram_gate_n,
  input  wire logic [7:0]  byte_lines_o,
  input  wire logic        byte_lines_oe,
  output var  logic [7:0]  byte_lines_i,
  output var  logic        clash
);
  // ****************************************
  // Storage and line drive
  // ****************************************
  logic [7:0] mem [0:524287];
  logic [7:0] last  = 8'h00;
  logic       drv   = 1'b0;
  logic       vld   = 1'b0;
  logic       wr_on = 1'b0;
  wire        rd_on = !sram_select_n && sram_write_n && !sram_gate_n;
  wire  [7:0] q     = mem[word_address];
  wire  [7:0] seen  = byte_lines_oe ? byte_lines_o : (vld ? q : ~q);

  // Turn-off is quicker than turn-on, so the lines are never fought over.
  always @(rd_on) drv <= #(rd_on ? 5 : 4) rd_on;

  // Until the access time runs out the wrong byte shows; slow mode uses the full 55 ns.
  // Select wakes the array at once, so no power-up delay is added to the access time.
  always @(rd_on) begin
    if (rd_on) begin
      vld <= #(slow ? 55 : 25) 1'b1;
    end else begin
      vld = 1'b0;
    end
  end

  // A released line shows the inverse of its last level, so a stale copy cannot pass.
  assign byte_lines_i = (byte_lines_oe || drv) ? seen : ~last;
  always @* if (byte_lines_oe || drv) last = seen;

  // Any moment where both sides drive is remembered for the bench.
  initial clash = 1'b0;
  always @* if (byte_lines_oe && drv) clash = 1'b1;

  // A write runs while select and strobe are both low; the first to rise stores the byte.
  always @(sram_select_n or sram_write_n) if (!sram_select_n && !sram_write_n) wr_on = 1'b1;
  always @(posedge sram_select_n or posedge sram_write_n) begin
    if (wr_on) mem[word_address] <= byte_lines_i;
    wr_on = 1'b0;
  end
endmodule

`default_nettype wire

// ==== verification/async_sram_512kx8_access_test.sv ====
// Self-checking testbench for the static memory access controller.
`timescale 1ns/100ps
`default_nettype none
`define CHK(what, exp, got) begin n_tests++; if ((got) !== (exp)) begin n_fail++; $display("[ERR] %s expected %h seen %h", what, exp, got); end end

module async_sram_512kx8_access_test;
  import asa_pkg::*;
  // ****************************************
  // Signals, clock and instances
  // ****************************************
  int          n_fail  = 0;
  int          n_tests = 0;
  logic        clk = 1'b0;
  logic        resetn = 1'b0;
  logic        req_valid = 1'b0;
  logic        req_write = 1'b0;
  logic        retention_req = 1'b0;
  logic        slow = 1'b0;
  logic [18:0] req_addr = 19'h00000;
  logic [7:0]  req_wdata = 8'h00;
  logic        req_ready, rsp_valid, done, retention_ready, clash;
  logic        sram_select_n, sram_write_n, sram_gate_n, byte_lines_oe;
  logic [18:0] word_address;
  logic [7:0]  rsp_rdata, byte_lines_o, byte_lines_i;

  initial forever #5 clk = ~clk;

  asa_ctrl u_asa_ctrl (.clk(clk), .resetn(resetn), .req_valid(req_valid), .req_ready(req_ready),
    .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata), .rsp_valid(rsp_valid),
    .rsp_rdata(rsp_rdata), .done(done), .retention_req(retention_req),
    .retention_ready(retention_ready), .word_address(word_address),
    .sram_select_n(sram_select_n), .sram_write_n(sram_write_n), .sram_gate_n(sram_gate_n),
    .byte_lines_o(byte_lines_o), .byte_lines_oe(byte_lines_oe), .byte_lines_i(byte_lines_i));

  asa_mem_model u_asa_mem_model (.slow(slow), .word_address(word_address),
    .sram_select_n(sram_select_n), .sram_write_n(sram_write_n), .sram_gate_n(sram_gate_n),
    .byte_lines_o(byte_lines_o), .byte_lines_oe(byte_lines_oe), .byte_lines_i(byte_lines_i),
    .clash(clash));

  // ****************************************
  // Access task and scenarios
  // ****************************************
  // Entered at a falling edge; pin activity is counted cycle by cycle until done.
  task automatic access(input logic wr, input logic [18:0] a, input logic [7:0] d,
                        input logic [7:0] exp);
    int k;
    int sel_low;
    int wr_low;
    int gate_low;
    int rsp_at;
    int strobe_len;
    k = 0;
    sel_low = 0;
    wr_low = 0;
    gate_low = 0;
    rsp_at = -1;
    strobe_len = wr ? WRITE_STROBE_CYC : READ_STROBE_CYC;
    req_valid = 1'b1;
    req_write = wr;
    req_addr = a;
    req_wdata = d;
    while (req_ready !== 1'b1) @(negedge clk);
    @(negedge clk);
    req_valid = 1'b0;
    while (done !== 1'b1 && k < 30) begin
      sel_low += (sram_select_n === 1'b0);
      wr_low += (sram_write_n === 1'b0);
      gate_low += (sram_gate_n === 1'b0);
      if (rsp_valid === 1'b1) rsp_at = k;
      @(negedge clk);
      k++;
    end
    `CHK("done latency", SETUP_CYC + strobe_len + RECOVER_CYC, k)
    `CHK("select low", strobe_len, sel_low)
    `CHK("strobe low", wr ? strobe_len : 0, wr_low)
    `CHK("gate low", wr ? 0 : strobe_len, gate_low)
    if (!wr) `CHK("read latency", SETUP_CYC + strobe_len, rsp_at)
    if (!wr) `CHK("read data", exp, rsp_rdata)
  endtask

  // Writes and reads at both ends of the address range.
  task automatic t_basic;
    access(1'b1, 19'h00000, 8'ha5, 8'h00);
    access(1'b1, 19'h7ffff, 8'h3c, 8'h00);
    access(1'b0, 19'h00000, 8'h00, 8'ha5);
    access(1'b0, 19'h7ffff, 8'h00, 8'h3c);
    $display("test basic finished");
  endtask

  // Back-to-back overwrite of one byte, then reads straight after each other.
  task automatic t_b2b;
    access(1'b1, 19'h12345, 8'h11, 8'h00);
    access(1'b1, 19'h12345, 8'hee, 8'h00);
    access(1'b0, 19'h12345, 8'h00, 8'hee);
    access(1'b0, 19'h00000, 8'h00, 8'ha5);
    $display("test back_to_back finished");
  endtask

  // The memory answers as late as allowed; all-zero and all-one bytes too.
  task automatic t_slow;
    slow = 1'b1;
    access(1'b1, 19'h40000, 8'h00, 8'h00);
    access(1'b1, 19'h00001, 8'hff, 8'h00);
    access(1'b0, 19'h40000, 8'h00, 8'h00);
    access(1'b0, 19'h00001, 8'h00, 8'hff);
    slow = 1'b0;
    $display("test slow_memory finished");
  endtask

  // While parked, a waiting request must not be taken and select stays high.
  task automatic t_retention;
    int i;
    retention_req = 1'b1;
    @(negedge clk);
    `CHK("retention ready", 1'b1, retention_ready)
    req_valid = 1'b1;
    req_write = 1'b1;
    req_addr = 19'h12345;
    req_wdata = 8'h77;
    for (i = 0; i < 4; i++) begin
      `CHK("held off", 3'b010, {req_ready, sram_select_n, done})
      @(negedge clk);
    end
    req_valid = 1'b0;
    retention_req = 1'b0;
    @(negedge clk);
    access(1'b0, 19'h12345, 8'h00, 8'hee);
    $display("test retention finished");
  endtask

  // ****************************************
  // Sequence, watchdog and verdict
  // ****************************************
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  initial begin
    repeat (16) @(negedge clk);
    resetn = 1'b1;
    @(negedge clk);
    `CHK("idle pins", 4'b1110, {sram_select_n, sram_write_n, sram_gate_n, byte_lines_oe})
    t_basic;
    t_b2b;
    t_slow;
    t_retention;
    `CHK("line clash", 1'b0, clash)
    end_of_test;
  end

  // The run needs some 160 cycles; nearly twenty times that means a hang.
  initial begin
    repeat (3000) @(posedge clk);
    n_fail++;
    $display("[ERR] watchdog expected finish seen timeout");
    end_of_test;
  end
endmodule

`default_nettype wire
